/* File: tb_usb_device_address_mode_control.sv */
// Register-level bench of the address and mode control block
`timescale 1ns/100ps
`default_nettype none
`include "uamc_defines.svh"
module tb_usb_device_address_mode_control;
	localparam logic [11:0] RA = `UAMC_OFF_ADDR;
	localparam logic [11:0] RM = `UAMC_OFF_MODE;
	localparam logic [11:0] RI = `UAMC_OFF_IRQ;
	localparam logic [11:0] RP = `UAMC_OFF_STAT;
	localparam int          SUSP = 20;
	localparam int          RDLY = 50;
	localparam int          RLEN = 100;
	logic                 clk, rst_n, psel, penable, pwrite, pready, pslverr, er;
	logic                 vbus, bus_rst, ack, dma_en, core_en, susp, rsm, irq;
	logic [11:0]          paddr;
	logic [31:0]          pwdata, prdata, rd;
	logic [7:0]           src;
	uamc_pkg::uamc_addr_t live;
	int                   num_errors, n_tests, n, base;
	int                   n_irq = 0;
	logic                 pm;
	uamc_top #(.SUSP_DELAY_CYC(SUSP), .RESUME_DELAY_CYC(RDLY), .RESUME_LEN_CYC(RLEN),
		.WAKE_STABLE_CYC(16), .NUM_IRQ(8)) dut (
		.clk_sys_in(clk), .reset_n_in(rst_n), .psel_in(psel), .penable_in(penable),
		.pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr), .vbus_pin_in(vbus),
		.bus_reset_in(bus_rst), .status_ack_in(ack), .irq_source_in(src),
		.irq_pulse_mode_in(pm), .live_addr_out(live), .dma_clk_en_out(dma_en),
		.core_clk_en_out(core_en), .suspended_out(susp), .resume_drive_out(rsm),
		.irq_out(irq));
	uamc_usb_host host (.clk_sys_in(clk), .vbus_out(vbus), .bus_reset_out(bus_rst),
		.status_ack_out(ack));
	always #5 clk = ~clk;
	// Pulse mode is judged by counting high irq cycles
	always @(posedge clk)
		if (irq === 1'h1)
			n_irq <= n_irq + 1;
	////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			num_errors++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		do
		begin
			@(posedge clk);
			k++;
		end
		while (pready !== 1'h1 && k < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (k >= 20)
			num_errors++;
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		apb(1'h0, a, 32'h0);
		chk(rd, exp);
	endtask
	task automatic wait_for(input int s, input logic v);
		n = 0;
		while ((s == 0 ? rsm : s == 1 ? core_en : susp) !== v && n < 400)
		begin
			@(posedge clk);
			n++;
		end
		// A wait that runs out is a mismatch
		if (n >= 400)
			num_errors++;
	endtask
	task automatic pulse(input logic [7:0] v);
		src <= v;
		repeat (3) @(posedge clk);
		src <= 8'h00;
		repeat (6) @(posedge clk);
	endtask
	task automatic summarize();
		$display("mismatches %0d, comparisons %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	// Whole run is a few hundred cycles
	initial
	begin
		#200000;
		num_errors++;
		summarize();
	end
	initial
	begin
		clk = 1'h0;
		rst_n = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		src = 8'h00;
		pm = 1'h0;
		num_errors = 0;
		n_tests = 0;
		repeat (3) @(posedge clk);
		rst_n <= 1'h1;
		rdc(RA, 32'h0);
		host.set_vbus(1'h1);
		repeat (4) @(posedge clk);
		rdc(RM, 32'h100);
		host.set_vbus(1'h0);
		apb(1'h1, RA, 32'hA5);
		rdc(RA, 32'hA5);
		chk(live, 32'h80);
		host.ack(3);
		repeat (6) @(posedge clk);
		chk(live, 32'hA5);
		apb(1'h0, 12'h204, 32'h0);
		chk(er, 32'h1);
		apb(1'h1, RM, 32'h200);
		repeat (3) @(posedge clk);
		chk(dma_en, 32'h1);
		apb(1'h1, RI, 32'h3);
		pulse(8'h01);
		chk(irq, 32'h0);
		apb(1'h1, RM, 32'h208);
		repeat (3) @(posedge clk);
		chk(irq, 32'h1);
		apb(1'h1, RP, 32'h1);
		pulse(8'h04);
		chk(irq, 32'h0);
		rdc(RP, 32'h4);
		host.bus_rst();
		repeat (6) @(posedge clk);
		rdc(RA, 32'h80);
		rdc(RM, 32'h8);
		chk(dma_en, 32'h0);
		apb(1'h1, RM, 32'h48);
		apb(1'h1, RM, 32'h8);
		wait_for(0, 1'h1);
		chk(n >= RDLY && n <= RDLY + 4, 32'h1);
		wait_for(0, 1'h0);
		chk(n >= RLEN && n <= RLEN + 1, 32'h1);
		apb(1'h1, RM, 32'h2C);
		apb(1'h1, RM, 32'hC);
		wait_for(2, 1'h1);
		chk(n <= 3, 32'h1);
		wait_for(1, 1'h0);
		chk(n + 3 >= SUSP && n <= SUSP + 2, 32'h1);
		rdc(RP, 32'h4);
		wait_for(1, 1'h1);
		repeat (16) @(posedge clk);
		chk(susp, 32'h0);
		apb(1'h1, RM, 32'hAC);
		apb(1'h1, RM, 32'h8C);
		wait_for(2, 1'h1);
		repeat (SUSP + 10) @(posedge clk);
		chk(core_en, 32'h1);
		rdc(RP, 32'h4);
		repeat (16) @(posedge clk);
		apb(1'h1, RA, 32'h85);
		apb(1'h1, RM, 32'h10);
		apb(1'h1, RM, 32'h0);
		repeat (3) @(posedge clk);
		rdc(RA, 32'h0);
		chk(live, 32'h0);
		// Pulse mode: gate closed, then opened with one event pending
		pm <= 1'h1;
		apb(1'h1, RI, 32'h1);
		base = n_irq;
		pulse(8'h01);
		chk(n_irq - base, 32'h0);
		apb(1'h1, RM, 32'h8);
		repeat (4) @(posedge clk);
		chk(n_irq - base, 32'h1);
		pulse(8'h01);
		chk(n_irq - base, 32'h2);
		pulse(8'h02);
		chk(n_irq - base, 32'h2);
		summarize();
	end
endmodule
`default_nettype wire

/* File: uamc_defines.svh */
// Offsets, field positions, reset values and timing counts of the mode/address block
`ifndef UAMC_DEFINES_SVH
`define UAMC_DEFINES_SVH
`define UAMC_OFF_ADDR          12'h200
`define UAMC_OFF_MODE          12'h20C
`define UAMC_OFF_IRQ           12'h214
`define UAMC_OFF_STAT          12'h218
`define UAMC_ADDR_EN_BIT       7
`define UAMC_MODE_DMACLK_BIT   9
`define UAMC_MODE_VBUS_BIT     8
`define UAMC_MODE_CLOCK_KEEP_RUNNING_BIT   7
`define UAMC_MODE_RESUME_BIT   6
`define UAMC_MODE_SUSP_BIT     5
`define UAMC_MODE_SFRST_BIT    4
`define UAMC_MODE_GLINT_BIT    3
`define UAMC_MODE_WAKE_BIT     2
`define UAMC_MODE_RSV0_BIT     0
`define UAMC_ADDR_RESET        8'h00
`define UAMC_MODE_RESET        16'h0000
`define UAMC_MODE_WMASK        16'h03FD
`define UAMC_MODE_BUSRST_KEEP  16'h0009
`define UAMC_CLK_PERIOD_NS     10
`define UAMC_SUSP_DELAY_US     2000
`define UAMC_RESUME_DELAY_US   5000
`define UAMC_RESUME_LEN_US     10000
`define UAMC_SUSP_DELAY_CYC    (`UAMC_SUSP_DELAY_US * 1000 / `UAMC_CLK_PERIOD_NS)
`define UAMC_RESUME_DELAY_CYC  (`UAMC_RESUME_DELAY_US * 1000 / `UAMC_CLK_PERIOD_NS)
`define UAMC_RESUME_LEN_CYC    (`UAMC_RESUME_LEN_US * 1000 / `UAMC_CLK_PERIOD_NS)
`define UAMC_WAKE_STABLE_CYC   16
`endif

/* File: uamc_pkg.sv */
// Types of the mode/address block
package uamc_pkg;
	typedef enum logic [1:0] {UAMC_RS_IDLE, UAMC_RS_WAIT, UAMC_RS_DRIVE} uamc_resume_st_t;
	typedef enum logic [1:0] {UAMC_PW_RUN, UAMC_PW_SUSP_WAIT, UAMC_PW_STOPPED} uamc_power_st_t;
	typedef struct packed {
		logic        respond_en;
		logic [6:0]  address;
	} uamc_addr_t;
endpackage

/* File: uamc_top.sv */
// Address and mode control registers of the USB peripheral, APB slave
//
// The APB slave port was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "uamc_defines.svh"

module uamc_top #(
	parameter int unsigned SUSP_DELAY_CYC   = `UAMC_SUSP_DELAY_CYC,
	parameter int unsigned RESUME_DELAY_CYC = `UAMC_RESUME_DELAY_CYC,
	parameter int unsigned RESUME_LEN_CYC   = `UAMC_RESUME_LEN_CYC,
	parameter int unsigned WAKE_STABLE_CYC  = `UAMC_WAKE_STABLE_CYC,
	parameter int unsigned NUM_IRQ          = 8
) (
	input  wire logic               clk_sys_in,
	input  wire logic               reset_n_in,
	input  wire logic               psel_in,
	input  wire logic               penable_in,
	input  wire logic               pwrite_in,
	input  wire logic [11:0]        paddr_in,
	input  wire logic [31:0]        pwdata_in,
	output logic      [31:0]        prdata_out,
	output logic                    pready_out,
	output logic                    pslverr_out,
	input  wire logic               vbus_pin_in,
	input  wire logic               bus_reset_in,
	input  wire logic               status_ack_in,
	input  wire logic [NUM_IRQ-1:0] irq_source_in,
	input  wire logic               irq_pulse_mode_in,
	output uamc_pkg::uamc_addr_t    live_addr_out,
	output logic                    dma_clk_en_out,
	output logic                    core_clk_en_out,
	output logic                    suspended_out,
	output logic                    resume_drive_out,
	output logic                    irq_out
);

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [1:0] vbus_sync_r;
	logic [1:0] busrst_sync_r;
	logic [1:0] ack_sync_r;
	logic [NUM_IRQ-1:0] irq_meta_r;
	logic [NUM_IRQ-1:0] irq_sync_r;

	always_ff @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			vbus_sync_r   <= 2'h0;
			busrst_sync_r <= 2'h0;
			ack_sync_r    <= 2'h0;
			irq_meta_r    <= '0;
			irq_sync_r    <= '0;
		end
		else
		begin
			vbus_sync_r   <= {vbus_sync_r[0], vbus_pin_in};
			busrst_sync_r <= {busrst_sync_r[0], bus_reset_in};
			ack_sync_r    <= {ack_sync_r[0], status_ack_in};
			irq_meta_r    <= irq_source_in;
			irq_sync_r    <= irq_meta_r;
		end
	end

	logic vbus_s;
	logic bus_rst_s;
	logic ack_s;
	assign vbus_s    = vbus_sync_r[1];
	assign bus_rst_s = busrst_sync_r[1];
	assign ack_s     = ack_sync_r[1];

	////////////////////////////////////////////////////////////////////////
	// APB decode; single-cycle access phase
	logic apb_wr;
	logic apb_rd;
	logic hit_addr;
	logic hit_mode;
	logic hit_irq;
	logic hit_stat;
	logic hit_any;

	assign apb_wr   = psel_in && penable_in && pwrite_in;
	assign apb_rd   = psel_in && penable_in && !pwrite_in;
	assign hit_addr = (paddr_in == `UAMC_OFF_ADDR);
	assign hit_mode = (paddr_in == `UAMC_OFF_MODE);
	assign hit_irq  = (paddr_in == `UAMC_OFF_IRQ);
	assign hit_stat = (paddr_in == `UAMC_OFF_STAT);
	assign hit_any  = hit_addr || hit_mode || hit_irq || hit_stat;

	////////////////////////////////////////////////////////////////////////
	// Soft reset: strobe on the falling write of the bit
	logic [15:0] mode_r;
	logic        soft_rst_r;
	logic        mode_fall_rst;
	logic        mode_fall_susp;
	logic        mode_fall_res;

	assign mode_fall_rst  = apb_wr && hit_mode && mode_r[`UAMC_MODE_SFRST_BIT]
		&& !pwdata_in[`UAMC_MODE_SFRST_BIT];
	assign mode_fall_susp = apb_wr && hit_mode && mode_r[`UAMC_MODE_SUSP_BIT]
		&& !pwdata_in[`UAMC_MODE_SUSP_BIT];
	assign mode_fall_res  = apb_wr && hit_mode && mode_r[`UAMC_MODE_RESUME_BIT]
		&& !pwdata_in[`UAMC_MODE_RESUME_BIT];

	always_ff @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			soft_rst_r <= 1'b0;
		else
			soft_rst_r <= mode_fall_rst;
	end

	////////////////////////////////////////////////////////////////////////
	// Address register, pending and live copies
	logic [7:0]  addr_r;
	logic        addr_pend_r;
	logic [7:0]  live_r;

	always_ff @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			addr_r      <= `UAMC_ADDR_RESET;
			addr_pend_r <= 1'b0;
			live_r      <= `UAMC_ADDR_RESET;
		end
		else if (soft_rst_r)
		begin
			addr_r      <= `UAMC_ADDR_RESET;
			addr_pend_r <= 1'b0;
			live_r      <= `UAMC_ADDR_RESET;
		end
		else if (bus_rst_s)
		begin
			addr_r[6:0] <= 7'h00;
			live_r[6:0] <= 7'h00;
			addr_pend_r <= 1'b0;
			live_r[`UAMC_ADDR_EN_BIT] <= addr_r[`UAMC_ADDR_EN_BIT];
		end
		else
		begin
			if (apb_wr && hit_addr)
			begin
				addr_r      <= pwdata_in[7:0];
				addr_pend_r <= 1'b1;
				// Enable acts at once; only the address waits for the handshake
				live_r[`UAMC_ADDR_EN_BIT] <= pwdata_in[`UAMC_ADDR_EN_BIT];
			end
			else if (addr_pend_r && ack_s)
			begin
				live_r[6:0] <= addr_r[6:0];
				addr_pend_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			live_addr_out <= '0;
		else
		begin
			live_addr_out.respond_en <= live_r[`UAMC_ADDR_EN_BIT];
			live_addr_out.address    <= live_r[6:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Mode register
	always_ff @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			mode_r <= `UAMC_MODE_RESET;
		else if (soft_rst_r)
			mode_r <= `UAMC_MODE_RESET;
		else if (bus_rst_s)
			mode_r <= mode_r & `UAMC_MODE_BUSRST_KEEP;
		else if (apb_wr && hit_mode)
			mode_r <= (pwdata_in[15:0] & `UAMC_MODE_WMASK)
				| (mode_r & ~`UAMC_MODE_WMASK);
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt mask and gating
	logic [NUM_IRQ-1:0] mask_r;
	logic [NUM_IRQ-1:0] pend_r;
	logic               gate;
	logic               gate_rise;
	logic               glint_q_r;

	assign gate      = mode_r[`UAMC_MODE_GLINT_BIT];
	assign gate_rise = gate && !glint_q_r;

	always_ff @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			mask_r <= '0;
		else if (soft_rst_r || bus_rst_s)
			mask_r <= '0;
		else if (apb_wr && hit_irq)
			mask_r <= pwdata_in[NUM_IRQ-1:0];
	end

	// Pending latch; set beats a clearing write
	genvar gi;
	generate
		for (gi = 0; gi < NUM_IRQ; gi++)
		begin : g_pend
			always_ff @(posedge clk_sys_in or negedge reset_n_in)
			begin
				if (!reset_n_in)
					pend_r[gi] <= 1'b0;
				else if (irq_sync_r[gi])
					pend_r[gi] <= 1'b1;
				else if (soft_rst_r || (apb_wr && hit_stat && pwdata_in[gi]))
					pend_r[gi] <= 1'b0;
			end
		end
	endgenerate

	logic irq_level;
	logic irq_new;
	logic [NUM_IRQ-1:0] irq_prev_r;
	assign irq_level = |(pend_r & mask_r);
	assign irq_new   = |(irq_sync_r & ~irq_prev_r & mask_r);

	always_ff @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			glint_q_r  <= 1'b0;
			irq_prev_r <= '0;
			irq_out    <= 1'b0;
		end
		else
		begin
			glint_q_r  <= gate;
			irq_prev_r <= irq_sync_r;
			if (!gate)
				irq_out <= 1'b0;
			else if (irq_pulse_mode_in)
				// Events pending when the gate opens are replayed as one pulse
				irq_out <= irq_new || (gate_rise && irq_level);
			else
				irq_out <= irq_level;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Suspend and clock control
	uamc_pkg::uamc_power_st_t pw_st_r;
	logic [31:0] pw_cnt_r;
	logic        wake_read;

	assign wake_read = apb_rd && hit_any && mode_r[`UAMC_MODE_WAKE_BIT]
		&& (pw_st_r != uamc_pkg::UAMC_PW_RUN);

	always_ff @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			pw_st_r  <= uamc_pkg::UAMC_PW_RUN;
			pw_cnt_r <= 32'h0;
		end
		else if (soft_rst_r || bus_rst_s || wake_read)
		begin
			pw_st_r  <= uamc_pkg::UAMC_PW_RUN;
			pw_cnt_r <= 32'h0;
		end
		else
		begin
			case (pw_st_r)
				uamc_pkg::UAMC_PW_RUN:
				begin
					pw_cnt_r <= 32'h0;
					if (mode_fall_susp)
						pw_st_r <= uamc_pkg::UAMC_PW_SUSP_WAIT;
				end
				uamc_pkg::UAMC_PW_SUSP_WAIT:
				begin
					if (mode_r[`UAMC_MODE_CLOCK_KEEP_RUNNING_BIT])
						pw_cnt_r <= 32'h0;
					else if (pw_cnt_r >= SUSP_DELAY_CYC - 1)
						pw_st_r <= uamc_pkg::UAMC_PW_STOPPED;
					else
						pw_cnt_r <= pw_cnt_r + 32'h1;
				end
				uamc_pkg::UAMC_PW_STOPPED:
				begin
					if (mode_r[`UAMC_MODE_CLOCK_KEEP_RUNNING_BIT])
						pw_st_r <= uamc_pkg::UAMC_PW_SUSP_WAIT;
				end
				default:
					pw_st_r <= uamc_pkg::UAMC_PW_RUN;
			endcase
		end
	end

	always_ff @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			suspended_out   <= 1'b0;
			core_clk_en_out <= 1'b1;
			dma_clk_en_out  <= 1'b0;
		end
		else
		begin
			suspended_out   <= (pw_st_r != uamc_pkg::UAMC_PW_RUN);
			core_clk_en_out <= (pw_st_r != uamc_pkg::UAMC_PW_STOPPED);
			dma_clk_en_out  <= mode_r[`UAMC_MODE_DMACLK_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Remote resume sequencer
	uamc_pkg::uamc_resume_st_t rs_st_r;
	logic [31:0] rs_cnt_r;

	always_ff @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			rs_st_r  <= uamc_pkg::UAMC_RS_IDLE;
			rs_cnt_r <= 32'h0;
		end
		else if (soft_rst_r || bus_rst_s)
		begin
			rs_st_r  <= uamc_pkg::UAMC_RS_IDLE;
			rs_cnt_r <= 32'h0;
		end
		else
		begin
			case (rs_st_r)
				uamc_pkg::UAMC_RS_IDLE:
				begin
					rs_cnt_r <= 32'h0;
					if (mode_fall_res)
						rs_st_r <= uamc_pkg::UAMC_RS_WAIT;
				end
				uamc_pkg::UAMC_RS_WAIT:
				begin
					if (rs_cnt_r >= RESUME_DELAY_CYC - 1)
					begin
						rs_cnt_r <= 32'h0;
						rs_st_r  <= uamc_pkg::UAMC_RS_DRIVE;
					end
					else
						rs_cnt_r <= rs_cnt_r + 32'h1;
				end
				uamc_pkg::UAMC_RS_DRIVE:
				begin
					if (rs_cnt_r >= RESUME_LEN_CYC - 1)
						rs_st_r <= uamc_pkg::UAMC_RS_IDLE;
					else
						rs_cnt_r <= rs_cnt_r + 32'h1;
				end
				default:
					rs_st_r <= uamc_pkg::UAMC_RS_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			resume_drive_out <= 1'b0;
		else
			resume_drive_out <= (rs_st_r == uamc_pkg::UAMC_RS_DRIVE);
	end

	////////////////////////////////////////////////////////////////////////
	// APB read data and response
	logic [31:0] rd_mux;
	always_comb
	begin
		rd_mux = 32'h0;
		if (hit_addr)
			rd_mux = {24'h0, addr_r};
		else if (hit_mode)
		begin
			rd_mux = {16'h0, mode_r};
			rd_mux[`UAMC_MODE_VBUS_BIT] = vbus_s;
		end
		else if (hit_irq)
			rd_mux[NUM_IRQ-1:0] = mask_r;
		else if (hit_stat)
			rd_mux[NUM_IRQ-1:0] = pend_r;
	end

	// Always ready in the cycle after setup so access completes in one cycle
	always_ff @(posedge clk_sys_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			prdata_out  <= 32'h0;
			pready_out  <= 1'b0;
			pslverr_out <= 1'b0;
		end
		else
		begin
			pready_out  <= psel_in && !penable_in;
			pslverr_out <= psel_in && !penable_in && !hit_any;
			prdata_out  <= (psel_in && !penable_in && !pwrite_in) ? rd_mux : 32'h0;
		end
	end

endmodule
`default_nettype wire

/* File: uamc_top_props.sv */
// Port checks of the address and mode control block
`timescale 1ns/100ps
`default_nettype none
`include "uamc_defines.svh"
module uamc_top_props #(
	parameter int unsigned SUSP_DELAY_CYC   = 20,
	parameter int unsigned RESUME_DELAY_CYC = 50,
	parameter int unsigned RESUME_LEN_CYC   = 100
) (
	input wire logic                 clk_sys_in,
	input wire logic                 reset_n_in,
	input wire logic                 psel_in,
	input wire logic                 penable_in,
	input wire logic                 pwrite_in,
	input wire logic [11:0]          paddr_in,
	input wire logic [31:0]          pwdata_in,
	input wire logic                 pready_out,
	input wire logic                 pslverr_out,
	input wire logic                 bus_reset_in,
	input wire logic                 status_ack_in,
	input wire uamc_pkg::uamc_addr_t live_addr_out,
	input wire logic                 dma_clk_en_out,
	input wire logic                 core_clk_en_out,
	input wire logic                 suspended_out,
	input wire logic                 resume_drive_out
);
	default clocking @(posedge clk_sys_in);
	endclocking
	default disable iff (!reset_n_in);
	////////////////////////////////////////////////////////////
	logic        mode_wr;
	logic [9:0]  last_mode_r;
	int unsigned gap_r;
	int unsigned run_r;
	int unsigned stop_r;
	assign mode_wr = psel_in && penable_in && pwrite_in && pready_out
		&& paddr_in == `UAMC_OFF_MODE;
	always_ff @(posedge clk_sys_in or negedge reset_n_in)
		if (!reset_n_in)
			last_mode_r <= 10'h000;
		else if (mode_wr)
			last_mode_r <= pwdata_in[9:0];
	// Counts from the write that clears the resume bit
	always_ff @(posedge clk_sys_in or negedge reset_n_in)
		if (!reset_n_in)
			gap_r <= 0;
		else if (mode_wr && last_mode_r[6] && !pwdata_in[6])
			gap_r <= 1;
		else if (gap_r != 0 && !resume_drive_out)
			gap_r <= gap_r + 1;
		else
			gap_r <= 0;
	always_ff @(posedge clk_sys_in or negedge reset_n_in)
		if (!reset_n_in)
			run_r <= 0;
		else
			run_r <= resume_drive_out ? run_r + 1 : 0;
	// Loose window: suspend entry lags the write by a cycle or two
	always_ff @(posedge clk_sys_in or negedge reset_n_in)
		if (!reset_n_in)
			stop_r <= 0;
		else
			stop_r <= (suspended_out && core_clk_en_out) ? stop_r + 1 : 0;
	////////////////////////////////////////////////////////////
	a_err_unmapped: assert property (pready_out |-> pslverr_out == !(paddr_in inside
		{`UAMC_OFF_ADDR, `UAMC_OFF_MODE, `UAMC_OFF_IRQ, `UAMC_OFF_STAT}))
		else $error("bad error response");
	a_enable_live: assert property (psel_in && penable_in && pwrite_in && pready_out
		&& paddr_in == `UAMC_OFF_ADDR |=> ##1
		live_addr_out.respond_en == $past(pwdata_in[7], 2))
		else $error("live enable not taken");
	a_addr_held: assert property ((!status_ack_in) [*6] |->
		$stable(live_addr_out.address) || live_addr_out.address == 7'h00)
		else $error("address moved without ack");
	a_bus_reset_addr: assert property (bus_reset_in [*6] |-> live_addr_out.address == 7'h00)
		else $error("address kept over bus reset");
	a_dma_follow: assert property (mode_wr && !bus_reset_in |=> ##1
		dma_clk_en_out == last_mode_r[9])
		else $error("dma clock wrong");
	a_resume_delay: assert property ($rose(resume_drive_out) |->
		gap_r inside {[RESUME_DELAY_CYC:RESUME_DELAY_CYC + 3]})
		else $error("resume delay wrong");
	a_resume_len: assert property ($fell(resume_drive_out) |->
		run_r inside {[RESUME_LEN_CYC:RESUME_LEN_CYC + 1]})
		else $error("resume length wrong");
	a_clock_stop: assert property ($fell(core_clk_en_out) |-> suspended_out &&
		stop_r inside {[SUSP_DELAY_CYC - 3:SUSP_DELAY_CYC + 2]})
		else $error("clock stop timing wrong");
endmodule

bind uamc_top uamc_top_props #(
	.SUSP_DELAY_CYC  (SUSP_DELAY_CYC),
	.RESUME_DELAY_CYC(RESUME_DELAY_CYC),
	.RESUME_LEN_CYC  (RESUME_LEN_CYC)
) u_props (
	.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .psel_in(psel_in),
	.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
	.pwdata_in(pwdata_in), .pready_out(pready_out), .pslverr_out(pslverr_out),
	.bus_reset_in(bus_reset_in), .status_ack_in(status_ack_in),
	.live_addr_out(live_addr_out), .dma_clk_en_out(dma_clk_en_out),
	.core_clk_en_out(core_clk_en_out), .suspended_out(suspended_out),
	.resume_drive_out(resume_drive_out)
);
`default_nettype wire

/* File: uamc_usb_host.sv */
// Host side model: bus power, bus reset, status acknowledge
`timescale 1ns/100ps
`default_nettype none
module uamc_usb_host (
	input  wire logic clk_sys_in,
	output logic      vbus_out,
	output logic      bus_reset_out,
	output logic      status_ack_out
);
	initial
	begin
		vbus_out = 1'h0;
		bus_reset_out = 1'h0;
		status_ack_out = 1'h0;
	end
	task automatic set_vbus(input logic v);
		@(posedge clk_sys_in);
		vbus_out <= v;
	endtask
	// Prompt or slow turnaround; two cycles so the synchroniser sees it
	task automatic ack(input int dly);
		repeat (dly) @(posedge clk_sys_in);
		status_ack_out <= 1'h1;
		repeat (2) @(posedge clk_sys_in);
		status_ack_out <= 1'h0;
	endtask
	task automatic bus_rst();
		@(posedge clk_sys_in);
		bus_reset_out <= 1'h1;
		repeat (10) @(posedge clk_sys_in);
		bus_reset_out <= 1'h0;
	endtask
endmodule
`default_nettype wire
